// ==== verilog/fqsg_status_group.sv ====
// Frequency status group: live lock condition, transition filters,
// destructive-read event register, enable mask and summary bit.
// Assumes lock inputs are synchronous to clk; commands one per cycle.
//
// Operation
// R01: Condition follows lock inputs every clock; writes to it are refused.
// R02: Bit 0 shows synthesizer unlocked.
// R03: Bit 1 shows 10 MHz reference unlocked.
// R04: Bit 2 shows 1 GHz reference unlocked.
// R05: Full variant: bit 3 shows baseband generator unlocked.
// R06: Bit 5 shows sampler loop unlocked.
// R07: Full variant: bit 6 shows tuned oscillator loop unlocked.
// R08: Full variant: bits 4, 7 to 15 always read zero.
// R09: Reduced variant: bits 3, 4, 6 to 15 read zero.
// R10: Build parameter ties the 1 GHz reference bit to zero.
// R11: Condition read returns the whole register as one value.
// R12: Rising condition bit sets event where positive filter enables it.
// R13: Falling condition bit sets event where negative filter enables it.
// R14: Event bits stay set until the event register is read.
// R15: Event read returns contents, then clears the register.
// R16: Summary is high while any enabled event bit is set.
// R17: Filter and enable masks read back as last written.
// R18: All registers 16 bits; edges compare against previous clock.
// R19: Reset clears events and enable, positive filter ones, negative zeros.
`include "fqsg_regs.svh"

module fqsg_status_group
	import fqsg_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1,
	parameter bit TIE_REF1G = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Live lock status
	input wire fqsg_lock_t lock_in,
	// Command port
	input wire fqsg_cmd_t cmd,
	output fqsg_rsp_t rsp_ff,
	// Summary to the parent condition register
	output logic summary
);

	localparam logic [`FQSG_W-1:0] BIT1 = 16'h0001;
	localparam logic [`FQSG_W-1:0] LIVE_MASK =
		(BIT1 << `FQSG_BIT_SYNTH) | (BIT1 << `FQSG_BIT_REF10) |
		(TIE_REF1G ? `FQSG_ZERO : (BIT1 << `FQSG_BIT_REF1G)) |
		(FULL_VARIANT ? (BIT1 << `FQSG_BIT_BBAND) : `FQSG_ZERO) |
		(BIT1 << `FQSG_BIT_SAMPLER) |
		(FULL_VARIANT ? (BIT1 << `FQSG_BIT_TUNED_OSC) : `FQSG_ZERO);

	logic [`FQSG_W-1:0] nxt_cond;
	logic [`FQSG_W-1:0] cond_ff;
	logic [`FQSG_W-1:0] prev_ff;
	logic [`FQSG_W-1:0] ptr_ff;
	logic [`FQSG_W-1:0] ntr_ff;
	logic [`FQSG_W-1:0] enable_ff;
	logic [`FQSG_W-1:0] event_ff;
	logic evt_read;
	logic wr_ptr;
	logic wr_ntr;
	logic wr_enable;
	fqsg_rsp_t nxt_rsp;

	// R02 R03 R04 R05 R06 R07 lock bit mapping
	// R08 R09 R10 unused and tied bits stay zero
	always_comb begin
		nxt_cond = `FQSG_ZERO;
		nxt_cond[`FQSG_BIT_SYNTH] = lock_in.synth_unlock;
		nxt_cond[`FQSG_BIT_REF10] = lock_in.ref10_unlock;
		nxt_cond[`FQSG_BIT_REF1G] = lock_in.ref1g_unlock;
		nxt_cond[`FQSG_BIT_BBAND] = lock_in.baseband_unlock;
		nxt_cond[`FQSG_BIT_SAMPLER] = lock_in.sampler_unlock;
		nxt_cond[`FQSG_BIT_TUNED_OSC] = lock_in.tuned_oscillator_loop_unlock;
		nxt_cond = nxt_cond & LIVE_MASK;
	end

	// R01 condition tracks inputs, no write path
	// R18 previous sample for edge detection
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cond_ff <= `FQSG_COND_RST;
			prev_ff <= `FQSG_COND_RST;
		end else begin
			cond_ff <= nxt_cond;
			prev_ff <= cond_ff;
		end
	end

	always_comb begin
		wr_ptr = cmd.valid && cmd.write && (cmd.sel == FQSG_SEL_PTR);
		wr_ntr = cmd.valid && cmd.write && (cmd.sel == FQSG_SEL_NTR);
		wr_enable = cmd.valid && cmd.write && (cmd.sel == FQSG_SEL_ENABLE);
		evt_read = cmd.valid && !cmd.write && (cmd.sel == FQSG_SEL_EVENT);
	end

	// R17 masks store the written weight sum
	// R19 filter reset values
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ptr_ff <= `FQSG_PTR_RST;
			ntr_ff <= `FQSG_NTR_RST;
		end else begin
			if (wr_ptr) begin
				ptr_ff <= cmd.wdata;
			end
			if (wr_ntr) begin
				ntr_ff <= cmd.wdata;
			end
		end
	end

	// R19 enable mask clears at reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			enable_ff <= `FQSG_ENABLE_RST;
		end else if (wr_enable) begin
			enable_ff <= cmd.wdata;
		end
	end

	// R12 R13 R14 filtered sticky events
	// R15 read clears, a new edge still wins
	fqsg_edge_latch #(
		.W(`FQSG_W)
	) u_edge_latch (
		.clk(clk),
		.rstn(rstn),
		.cond(cond_ff),
		.prev(prev_ff),
		.rise_mask(ptr_ff),
		.fall_mask(ntr_ff),
		.clear(evt_read),
		.event_ff(event_ff)
	);

	// R16 summary of enabled events
	assign summary = |(event_ff & enable_ff);

	// R11 R15 R17 read answers; refused writes flag an error
	always_comb begin
		nxt_rsp.valid = cmd.valid;
		nxt_rsp.err = 1'b0;
		nxt_rsp.data = `FQSG_ZERO;
		if (cmd.valid) begin
			case (cmd.sel)
				FQSG_SEL_COND: begin
					nxt_rsp.err = cmd.write;
					nxt_rsp.data = cmd.write ? `FQSG_ZERO : cond_ff;
				end
				FQSG_SEL_PTR: begin
					nxt_rsp.data = cmd.write ? `FQSG_ZERO : ptr_ff;
				end
				FQSG_SEL_NTR: begin
					nxt_rsp.data = cmd.write ? `FQSG_ZERO : ntr_ff;
				end
				FQSG_SEL_EVENT: begin
					nxt_rsp.err = cmd.write;
					nxt_rsp.data = cmd.write ? `FQSG_ZERO : event_ff;
				end
				FQSG_SEL_ENABLE: begin
					nxt_rsp.data = cmd.write ? `FQSG_ZERO : enable_ff;
				end
				default: begin
					nxt_rsp.err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	// Helper state for the checks below
	logic run_ff;
	logic first_ff;
	logic [`FQSG_W-1:0] rise_hit;
	logic [`FQSG_W-1:0] fall_hit;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			run_ff <= 1'b0;
			first_ff <= 1'b1;
		end else begin
			run_ff <= 1'b1;
			first_ff <= 1'b0;
		end
	end

	always_comb begin
		rise_hit = cond_ff & ~prev_ff & ptr_ff;
		fall_hit = ~cond_ff & prev_ff & ntr_ff;
	end

	sequence s_mask_write;
		wr_enable;
	endsequence

	sequence s_enable_read;
		cmd.valid && !cmd.write && (cmd.sel == FQSG_SEL_ENABLE);
	endsequence

	// R01 condition mirrors inputs
	chk_cond_tracks: assert property (@(posedge clk) disable iff (!rstn) // R01
		run_ff |-> (cond_ff == ($past(nxt_cond))))
		else $error("condition does not track lock inputs");

	// R02 synthesizer bit
	chk_synth_bit: assert property (@(posedge clk) disable iff (!rstn) // R02
		run_ff |-> (cond_ff[`FQSG_BIT_SYNTH] == $past(lock_in.synth_unlock)))
		else $error("synthesizer bit wrong");

	// R06 sampler bit
	chk_sampler_bit: assert property (@(posedge clk) disable iff (!rstn) // R06
		run_ff |-> (cond_ff[`FQSG_BIT_SAMPLER] == $past(lock_in.sampler_unlock)))
		else $error("sampler bit wrong");

	// R03 10 MHz reference bit
	chk_ref10_bit: assert property (@(posedge clk) disable iff (!rstn) // R03
		run_ff |-> (cond_ff[`FQSG_BIT_REF10] == $past(lock_in.ref10_unlock)))
		else $error("10 MHz reference bit wrong");

	// R04 R10 1 GHz reference or tie-off
	chk_ref1g_bit: assert property (@(posedge clk) disable iff (!rstn) // R04
		run_ff |-> (cond_ff[`FQSG_BIT_REF1G] == (!TIE_REF1G && $past(lock_in.ref1g_unlock))))
		else $error("1 GHz reference bit wrong");

	// R05 R09 baseband bit in full build only
	chk_bband_bit: assert property (@(posedge clk) disable iff (!rstn) // R05
		run_ff |-> (cond_ff[`FQSG_BIT_BBAND] ==
			(FULL_VARIANT && $past(lock_in.baseband_unlock))))
		else $error("baseband bit wrong");

	// R07 R09 oscillator loop bit in full build only
	chk_tuned_bit: assert property (@(posedge clk) disable iff (!rstn) // R07
		run_ff |-> (cond_ff[`FQSG_BIT_TUNED_OSC] ==
			(FULL_VARIANT && $past(lock_in.tuned_oscillator_loop_unlock))))
		else $error("oscillator loop bit wrong");

	// R11 condition read returns whole value
	chk_cond_read: assert property (@(posedge clk) disable iff (!rstn) // R11
		(cmd.valid && !cmd.write && (cmd.sel == FQSG_SEL_COND)) |=>
			(rsp_ff.data == $past(cond_ff)))
		else $error("condition read value wrong");

	// R08 R09 R10 unused bits zero
	chk_unused_zero: assert property (@(posedge clk) disable iff (!rstn) // R08
		(cond_ff & ~LIVE_MASK) == `FQSG_ZERO)
		else $error("unused condition bit set");

	// R12 rising edge latches
	chk_rise_sets: assert property (@(posedge clk) disable iff (!rstn) // R12
		(rise_hit != `FQSG_ZERO) |=> ((event_ff & $past(rise_hit)) == $past(rise_hit)))
		else $error("positive transition lost");

	// R13 falling edge latches
	chk_fall_sets: assert property (@(posedge clk) disable iff (!rstn) // R13
		(fall_hit != `FQSG_ZERO) |=> ((event_ff & $past(fall_hit)) == $past(fall_hit)))
		else $error("negative transition lost");

	// R15 event writes leave events alone
	chk_evt_write_ro: assert property (@(posedge clk) disable iff (!rstn) // R15
		(cmd.valid && cmd.write && (cmd.sel == FQSG_SEL_EVENT)) |=>
			(rsp_ff.err && (event_ff ==
				($past(event_ff) | $past(rise_hit) | $past(fall_hit)))))
		else $error("event write not refused");

	// R14 events are sticky
	chk_evt_sticky: assert property (@(posedge clk) disable iff (!rstn) // R14
		!evt_read |=> ((event_ff & $past(event_ff)) == $past(event_ff)))
		else $error("event bit dropped without read");

	// R15 read returns then clears
	chk_evt_read: assert property (@(posedge clk) disable iff (!rstn) // R15
		evt_read |=> (rsp_ff.valid && (rsp_ff.data == $past(event_ff)) &&
			(event_ff == ($past(rise_hit) | $past(fall_hit)))))
		else $error("event read did not return and clear");

	// R16 summary follows an enable write
	chk_summary_on: assert property (@(posedge clk) disable iff (!rstn) // R16
		(wr_enable && !evt_read && ((cmd.wdata & event_ff) != `FQSG_ZERO)) |=> summary)
		else $error("summary not raised");

	// R17 enable stores written sum
	chk_mask_store: assert property (@(posedge clk) disable iff (!rstn) // R17
		s_mask_write |=> (enable_ff == $past(cmd.wdata)))
		else $error("enable write not stored");

	// R17 enable readback
	chk_mask_back: assert property (@(posedge clk) disable iff (!rstn) // R17
		s_enable_read |=> (rsp_ff.valid && (rsp_ff.data == $past(enable_ff))))
		else $error("enable readback mismatch");

	// R01 condition writes refused
	chk_cond_ro: assert property (@(posedge clk) disable iff (!rstn) // R01
		(cmd.valid && cmd.write && (cmd.sel == FQSG_SEL_COND)) |=> rsp_ff.err)
		else $error("condition write not refused");

	// R19 values after reset release
	chk_reset_vals: assert property (@(posedge clk) disable iff (!rstn) // R19
		first_ff |-> ((ptr_ff == `FQSG_PTR_RST) && (ntr_ff == `FQSG_NTR_RST) &&
			(enable_ff == `FQSG_ENABLE_RST) && (event_ff == `FQSG_EVENT_RST)))
		else $error("reset values wrong");

endmodule : fqsg_status_group

// ==== include/fqsg_regs.svh ====
// Constants of the frequency status group: widths, bit positions,
// register select codes and reset values.
// Assumes it is included by the package and the modules that need it.
`ifndef FQSG_REGS_SVH
`define FQSG_REGS_SVH

`define FQSG_W 16
`define FQSG_SEL_W 3

// Condition bit positions
`define FQSG_BIT_SYNTH 0
`define FQSG_BIT_REF10 1
`define FQSG_BIT_REF1G 2
`define FQSG_BIT_BBAND 3
`define FQSG_BIT_SAMPLER 5
`define FQSG_BIT_TUNED_OSC 6

// Register select codes of the command port
`define FQSG_SEL_COND 3'h0
`define FQSG_SEL_PTR 3'h1
`define FQSG_SEL_NTR 3'h2
`define FQSG_SEL_EVENT 3'h3
`define FQSG_SEL_ENABLE 3'h4

// Reset values
`define FQSG_COND_RST 16'h0000
`define FQSG_PTR_RST 16'hFFFF
`define FQSG_NTR_RST 16'h0000
`define FQSG_EVENT_RST 16'h0000
`define FQSG_ENABLE_RST 16'h0000
`define FQSG_ZERO 16'h0000

`endif

// ==== include/fqsg_pkg.sv ====
// Types of the frequency status group: register selects, command,
// response and lock status carriers.
// Assumes fqsg_regs.svh is on the include path.
`include "fqsg_regs.svh"

package fqsg_pkg;

	typedef enum logic [`FQSG_SEL_W-1:0] {
		FQSG_SEL_COND = `FQSG_SEL_COND,
		FQSG_SEL_PTR = `FQSG_SEL_PTR,
		FQSG_SEL_NTR = `FQSG_SEL_NTR,
		FQSG_SEL_EVENT = `FQSG_SEL_EVENT,
		FQSG_SEL_ENABLE = `FQSG_SEL_ENABLE
	} fqsg_sel_t;

	typedef struct packed {
		logic valid;
		logic write;
		fqsg_sel_t sel;
		logic [`FQSG_W-1:0] wdata;
	} fqsg_cmd_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [`FQSG_W-1:0] data;
	} fqsg_rsp_t;

	typedef struct packed {
		logic synth_unlock;
		logic ref10_unlock;
		logic ref1g_unlock;
		logic baseband_unlock;
		logic sampler_unlock;
		logic tuned_oscillator_loop_unlock;
	} fqsg_lock_t;

endpackage : fqsg_pkg

// ==== verilog/fqsg_edge_latch.sv ====
// Sticky edge latch: per-bit rising and falling detection gated by
// two filters, with a clear that loses to a simultaneous set.
// Assumes cond and prev are registered one clock apart by the caller.
`include "fqsg_regs.svh"

module fqsg_edge_latch #(
	parameter int W = `FQSG_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Condition now and one clock earlier
	input wire logic [W-1:0] cond,
	input wire logic [W-1:0] prev,
	// Filters
	input wire logic [W-1:0] rise_mask,
	input wire logic [W-1:0] fall_mask,
	// Clear request
	input wire logic clear,
	// Latched events
	output logic [W-1:0] event_ff
);

	logic [W-1:0] set_bits;
	logic [W-1:0] nxt_event;

	always_comb begin
		set_bits = (cond & ~prev & rise_mask) | (~cond & prev & fall_mask);
		// A set in the clearing cycle survives
		nxt_event = (clear ? {W{1'b0}} : event_ff) | set_bits;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			event_ff <= W'(`FQSG_EVENT_RST);
		end else begin
			event_ff <= nxt_event;
		end
	end

endmodule : fqsg_edge_latch

// ==== verif/fqsg_tb_top.sv ====
// Testbench of the frequency status group: command port, lock inputs
// and summary, on a full build and on a reduced build with 1 GHz tied.
// Assumes the design carries its own timing assertions.
`include "fqsg_regs.svh"

module tb_top
	import fqsg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk;
	logic rstn;
	fqsg_lock_t lock_in;
	fqsg_cmd_t cmd;
	fqsg_rsp_t rsp_ff;
	fqsg_rsp_t rsp_red;
	logic summary;
	logic [15:0] rd;
	logic [15:0] red_data;
	int miscompares;
	int compares;

	fqsg_status_group dut_u (
		.clk(clk), .rstn(rstn), .lock_in(lock_in), .cmd(cmd), .rsp_ff(rsp_ff),
		.summary(summary)
	);

	// Reduced map: no baseband or oscillator loop, 1 GHz reference tied off
	fqsg_status_group #(.FULL_VARIANT(1'b0), .TIE_REF1G(1'b1)) dut_red_u (
		.clk(clk), .rstn(rstn), .lock_in(lock_in), .cmd(cmd), .rsp_ff(rsp_red),
		.summary()
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			$display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
			miscompares++;
		end
	endtask : chk

	// One request, then the registered answer is sampled one clock later
	task op(input logic wr, input logic [2:0] s, input logic [15:0] wd, input logic e);
		@(negedge clk);
		cmd = '{valid: 1'b1, write: wr, sel: fqsg_sel_t'(s), wdata: wd};
		@(negedge clk);
		rd = rsp_ff.data;
		red_data = rsp_red.data;
		chk({15'h0000, rsp_ff.valid}, 16'h0001, "response valid");
		chk({15'h0000, rsp_ff.err}, {15'h0000, e}, "response error flag");
		cmd = '0;
	endtask : op

	task settle(input fqsg_lock_t l);
		@(negedge clk);
		lock_in = l;
		repeat (3) @(negedge clk);
	endtask : settle

	task t_reset;
		logic [15:0] rv [5];
		rv = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 5; i++) begin
			op(1'b0, i[2:0], 16'h0000, 1'b0);
			chk(rd, rv[i], "reset value");
		end
		op(1'b0, 3'h5, 16'h0000, 1'b1);
		chk(rd, 16'h0000, "unmapped read data");
		op(1'b1, 3'h3, 16'hFFFF, 1'b1);
		$display("test reset done");
	endtask : t_reset

	task t_cond;
		int pos [6];
		logic [15:0] red_exp [6];
		pos = '{0, 1, 2, 3, 5, 6};
		red_exp = '{16'h0001, 16'h0002, 16'h0000, 16'h0000, 16'h0020, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			settle(fqsg_lock_t'(6'h20 >> i));
			op(1'b0, 3'h0, 16'h0000, 1'b0);
			chk(rd, 16'h0001 << pos[i], "full condition bit");
			chk(red_data, red_exp[i], "reduced condition bit");
		end
		settle(fqsg_lock_t'(6'h3F));
		op(1'b1, 3'h0, 16'h0000, 1'b1);
		op(1'b0, 3'h0, 16'h0000, 1'b0);
		chk(rd, 16'h006F, "condition sum");
		chk(red_data, 16'h0023, "reduced condition sum");
		settle(fqsg_lock_t'(6'h00));
		// All rises passed the default positive filter, none enabled yet
		chk({15'h0000, summary}, 16'h0000, "summary masked");
		op(1'b1, 3'h4, 16'h0004, 1'b0);
		chk({15'h0000, summary}, 16'h0001, "summary enabled");
		op(1'b0, 3'h3, 16'h0000, 1'b0);
		chk(rd, 16'h006F, "latched events");
		chk(red_data, 16'h0023, "reduced latched events");
		chk({15'h0000, summary}, 16'h0000, "summary after clear");
		op(1'b0, 3'h3, 16'h0000, 1'b0);
		chk(rd, 16'h0000, "event cleared");
		$display("test condition done");
	endtask : t_cond

	task t_filter;
		logic [15:0] wv [3];
		wv = '{16'h0001, 16'h0021, 16'h0021};
		for (int i = 0; i < 3; i++) begin
			op(1'b1, 3'h1 + i * 3'h1 + (i == 2 ? 3'h1 : 3'h0), wv[i], 1'b0);
		end
		for (int i = 0; i < 3; i++) begin
			op(1'b0, 3'h1 + i * 3'h1 + (i == 2 ? 3'h1 : 3'h0), 16'h0000, 1'b0);
			chk(rd, wv[i], "mask readback");
		end
		settle('{synth_unlock: 1'b1, sampler_unlock: 1'b1, default: 1'b0});
		chk({15'h0000, summary}, 16'h0001, "summary on rise");
		op(1'b0, 3'h3, 16'h0000, 1'b0);
		chk(rd, 16'h0001, "rise filtered");
		settle(fqsg_lock_t'(6'h00));
		op(1'b0, 3'h3, 16'h0000, 1'b0);
		chk(rd, 16'h0021, "fall filtered");
		$display("test filters done");
	endtask : t_filter

	task print_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (3000) @(posedge clk);
		$display("BAD at %0t: watchdog expired", $time);
		miscompares++;
		print_verdict();
	end

	initial begin
		miscompares = 0;
		compares = 0;
		rstn = 1'b0;
		lock_in = '0;
		cmd = '0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_cond();
		t_filter();
		print_verdict();
	end

endmodule : tb_top
